// File: design/sapc_checker.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module sapc_checker #(
  parameter int NSLOT  = sapc_pkg::NSLOT,
  parameter int SLOT_W = sapc_pkg::SLOT_W
) (
  input  wire logic                    aclk,           // clock, 50 MHz
  input  wire logic                    aresetn,        // sync reset, low
  input  wire logic                    ce,             // clock enable
  input  wire logic [11:0]             s_axi_awaddr,   // write address
  input  wire logic                    s_axi_awvalid,  // write address valid
  output logic                         s_axi_awready,  // write address ready
  input  wire logic [31:0]             s_axi_wdata,    // write data
  input  wire logic [3:0]              s_axi_wstrb,    // byte strobes
  input  wire logic                    s_axi_wvalid,   // write data valid
  output logic                         s_axi_wready,   // write data ready
  output logic [1:0]                   s_axi_bresp,    // write response
  output logic                         s_axi_bvalid,   // write response valid
  input  wire logic                    s_axi_bready,   // write response ready
  input  wire logic [11:0]             s_axi_araddr,   // read address
  input  wire logic                    s_axi_arvalid,  // read address valid
  output logic                         s_axi_arready,  // read address ready
  output logic [31:0]                  s_axi_rdata,    // read data
  output logic [1:0]                   s_axi_rresp,    // read response
  output logic                         s_axi_rvalid,   // read data valid
  input  wire logic                    s_axi_rready,   // read data ready
  input  wire logic                    req_valid,      // access request
  output logic                         req_ready,      // request taken
  input  wire sapc_pkg::sapc_cmd_t     req_cmd,        // command kind
  input  wire logic [SLOT_W-1:0]       req_slot,       // target slot
  input  wire logic                    req_len32,      // 32-byte, else 4-byte
  input  wire logic                    req_encrypted,  // write data encrypted
  input  wire logic                    req_mac_ok,     // input MAC good
  input  wire logic                    req_for_verify, // digest feeds verify
  input  wire logic                    req_copy,       // verify copy from slot
  output logic                         rsp_valid,      // decision pulse
  output logic                         rsp_grant,      // access permitted
  output logic                         rsp_error,      // access refused
  output logic                         rsp_encrypt,    // encrypt read data
  output logic [SLOT_W-1:0]            rsp_key_slot,   // key slot to use
  output logic                         rsp_mac_req,    // MAC demanded
  output logic                         rsp_limited,    // limited-use key
  output logic                         rsp_parent_src  // derive from parent
);
  import sapc_pkg::*;

  if (NSLOT != (1 << SLOT_W) || SLOT_W != 4) begin : g_bad
    $error("slot count must be sixteen");
  end

  logic [15:0]       policy_reg [NSLOT];
  logic [7:0]        data_lock_reg;
  logic [7:0]        cfg_lock_reg;
  logic [15:0]       refuse_cnt_reg;
  logic [NSLOT-1:0]  pol_hit;
  logic              wr_en;
  logic [11:0]       wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic [11:0]       rd_addr;
  logic [31:0]       rd_data;
  logic              rd_err;
  logic              dz_locked;
  logic              cz_locked;
  logic              req_fire;
  logic [15:0]       sel_word;
  logic              d_grant;
  logic [3:0]        d_key;
  logic              d_enc;
  logic              d_mac;
  logic              d_lim;
  logic              d_par;

  assign dz_locked = data_lock_reg != LOCK_OPEN;
  assign cz_locked = cfg_lock_reg != LOCK_OPEN;
  assign req_ready = ce;
  assign req_fire  = ce && req_valid;
  assign sel_word  = policy_reg[req_slot];

  sapc_axil #(
    .AW (ADDR_W)
  ) u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ce            (ce),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // one policy word per slot, writable only while the config zone is open
  for (genvar i = 0; i < NSLOT; i++) begin : g_slot
    assign pol_hit[i] = wr_addr == POLICY_BASE + 12'(i) * WORD_STRIDE;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        policy_reg[i] <= POLICY_RESET;
      end else if (ce && wr_en && pol_hit[i] && !cz_locked) begin
        if (wr_strb[0]) begin
          policy_reg[i][7:0] <= wr_data[7:0];
        end
        if (wr_strb[1]) begin
          policy_reg[i][15:8] <= wr_data[15:8];
        end
      end
    end
  end

  always_comb begin
    wr_err = 1'b1;
    if (|pol_hit) begin
      wr_err = cz_locked;
    end else if (wr_addr == LOCK_OFFS) begin
      wr_err = 1'b0;
    end
  end

  // locks only ever close; the data zone closes after the config zone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_lock_reg <= LOCK_OPEN;
      cfg_lock_reg  <= LOCK_OPEN;
    end else if (ce && wr_en && wr_addr == LOCK_OFFS) begin
      if (wr_strb[1] && wr_data[15:8] == LOCK_SHUT) begin
        cfg_lock_reg <= LOCK_SHUT;
      end
      if (wr_strb[0] && wr_data[7:0] == LOCK_SHUT && cz_locked) begin
        data_lock_reg <= LOCK_SHUT;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (rd_addr >= POLICY_BASE && rd_addr < POLICY_BASE + 12'(NSLOT) * WORD_STRIDE
        && rd_addr[1:0] == 2'h0) begin
      rd_data[15:0] = policy_reg[4'((rd_addr - POLICY_BASE) >> 2)];
    end else if (rd_addr == LOCK_OFFS) begin
      rd_data[15:0] = {cfg_lock_reg, data_lock_reg};
    end else if (rd_addr == STATUS_OFFS) begin
      rd_data = {refuse_cnt_reg, 8'h00, rsp_key_slot, 2'h0, rsp_error, rsp_grant};
    end else begin
      rd_err = 1'b1;
    end
  end

  sapc_decode u_decode (
    .word       (sel_word),
    .slot       (req_slot),
    .cmd        (req_cmd),
    .len32      (req_len32),
    .enc        (req_encrypted),
    .mac_ok     (req_mac_ok),
    .for_verify (req_for_verify),
    .copy_req   (req_copy),
    .dz_locked  (dz_locked),
    .cz_locked  (cz_locked),
    .grant      (d_grant),
    .key_slot   (d_key),
    .encrypt    (d_enc),
    .mac_req    (d_mac),
    .limited    (d_lim),
    .parent_src (d_par)
  );

  // decision stands one cycle after the request; fields hold until the next
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_valid      <= 1'b0;
      rsp_grant      <= 1'b0;
      rsp_error      <= 1'b0;
      rsp_encrypt    <= 1'b0;
      rsp_key_slot   <= '0;
      rsp_mac_req    <= 1'b0;
      rsp_limited    <= 1'b0;
      rsp_parent_src <= 1'b0;
    end else if (ce) begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp_grant      <= d_grant;
        rsp_error      <= !d_grant;
        rsp_encrypt    <= d_enc;
        rsp_key_slot   <= d_key;
        rsp_mac_req    <= d_mac;
        rsp_limited    <= d_lim;
        rsp_parent_src <= d_par;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refuse_cnt_reg <= 16'h0000;
    end else if (req_fire && !d_grant && refuse_cnt_reg != 16'hFFFF) begin
      refuse_cnt_reg <= refuse_cnt_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_req(sapc_cmd_t c);
    req_fire && req_cmd == c;
  endsequence
  sequence s_open;
    dz_locked && cz_locked;
  endsequence

  a_unlocked_read_ref: assert property (s_req(CMD_READ) ##0 !dz_locked |=> rsp_valid && rsp_error)
    else $error("read granted while data zone open");
  a_unlocked_write_ok: assert property (s_req(CMD_WRITE) ##0 (!dz_locked && cz_locked) |=> rsp_grant)
    else $error("write refused while data zone open");
  a_preconfig_error: assert property ((s_req(CMD_READ) or s_req(CMD_WRITE)) ##0 !cz_locked |=> rsp_error)
    else $error("data access allowed before config lock");
  a_cipher_key_slot: assert property (s_req(CMD_READ) ##0 s_open ##0 (sel_word[7:6] == 2'h3 && req_len32)
    |=> rsp_encrypt && rsp_key_slot == $past(sel_word[3:0]))
    else $error("encrypted read used wrong key");
  a_secret_no_read: assert property (s_req(CMD_READ) ##0 (sel_word[7:6] == 2'h2) |=> rsp_error)
    else $error("secret slot read granted");
  a_short_secret: assert property ((s_req(CMD_READ) or s_req(CMD_WRITE)) ##0 s_open
    ##0 (sel_word[SECRET_BIT] && !req_len32) |=> rsp_error)
    else $error("4-byte access to secret slot");
  a_clear_read_ok: assert property (s_req(CMD_READ) ##0 s_open ##0 (sel_word[7:6] == 2'h0)
    |=> rsp_grant && !rsp_encrypt)
    else $error("clear read refused");
  a_write_never: assert property (s_req(CMD_WRITE) ##0 s_open
    ##0 (sel_word[14:13] == 2'h1 || sel_word[15:14] == 2'h2) |=> rsp_error)
    else $error("write to never slot granted");
  a_derive_target: assert property (s_req(CMD_DERIVE) ##0 !sel_word[13] |=> rsp_error)
    else $error("rollover on non-target slot");
  a_verify_only: assert property (s_req(CMD_CRYPTO) ##0 sel_word[VERIFY_BIT] |=> rsp_error)
    else $error("verify-only key used elsewhere");
  a_copy_source: assert property (s_req(CMD_MAC_VERIFY) ##0 req_copy
    |=> rsp_grant == ($past(sel_word[3:0]) == 4'h0))
    else $error("copy source check wrong");
  a_refuse_quiet: assert property (rsp_error |-> !rsp_grant && !rsp_encrypt && rsp_key_slot == 4'h0)
    else $error("refusal carries key data");
  a_lock_sticky: assert property (dz_locked |=> dz_locked [*2])
    else $error("data zone reopened");

  sequence s_parent_code;
    sel_word[13:12] == 2'h3 && (!sel_word[15] || req_mac_ok) && !sel_word[VERIFY_BIT];
  endsequence

  a_rsp_one_cycle: assert property (req_fire |=> rsp_valid)
    else $error("decision pulse missing");
  a_derive_parent: assert property (s_req(CMD_DERIVE) ##0 s_parent_code
    |=> rsp_grant && rsp_parent_src && rsp_key_slot == $past(sel_word[11:8]))
    else $error("parent rollover decoded wrong");
  a_enc_write_need: assert property (s_req(CMD_WRITE) ##0 s_open ##0 sel_word[14]
    ##0 !(req_encrypted && req_mac_ok && req_len32) |=> rsp_error)
    else $error("encrypted write granted without proof");
  a_limit_ignored: assert property (req_fire ##0 (req_slot >= 4'h8 && req_slot <= 4'hE) |=> !rsp_limited)
    else $error("limited flag set for exempt slot");
  a_lock_order: assert property (!cz_locked |-> !dz_locked)
    else $error("data zone locked before config zone");
  a_decision_exclusive: assert property (rsp_valid |-> rsp_grant != rsp_error)
    else $error("decision both granted and refused");
endmodule

// File: design/sapc_pkg.sv
package sapc_pkg;
  localparam int          SLOT_W        = 4;
  localparam int          NSLOT         = 16;
  localparam int          WORD_W        = 16;
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] POLICY_BASE   = 12'h014;
  localparam logic [11:0] WORD_STRIDE   = 12'h004;
  localparam logic [11:0] LOCK_OFFS     = 12'h060;
  localparam logic [11:0] STATUS_OFFS   = 12'h064;
  localparam logic [15:0] POLICY_RESET  = 16'h0000;
  localparam logic [7:0]  LOCK_OPEN     = 8'h55;
  localparam logic [7:0]  LOCK_SHUT     = 8'h00;
  localparam int          RDKEY_LSB     = 0;
  localparam int          VERIFY_BIT    = 4;
  localparam int          LIMITED_BIT   = 5;
  localparam int          CIPHER_BIT    = 6;
  localparam int          SECRET_BIT    = 7;
  localparam int          WKEY_LSB      = 8;
  localparam int          WPOL_LSB      = 12;
  localparam logic [3:0]  LIMIT_IGN_LO  = 4'h8;
  localparam logic [3:0]  LIMIT_IGN_HI  = 4'hE;
  localparam logic [1:0]  AXI_OKAY      = 2'h0;
  localparam logic [1:0]  AXI_SLVERR    = 2'h2;
  typedef enum logic [2:0] {
    CMD_READ       = 3'h0,
    CMD_WRITE      = 3'h1,
    CMD_DERIVE     = 3'h3,
    CMD_MAC_VERIFY = 3'h2,
    CMD_DIGEST     = 3'h6,
    CMD_CRYPTO     = 3'h7
  } sapc_cmd_t;
endpackage

// File: design/sapc_axil.sv
`timescale 1ns/1ns
module sapc_axil #(
  parameter int AW = 12
) (
  input  wire logic          aclk,           // clock
  input  wire logic          aresetn,        // sync reset, low
  input  wire logic          ce,             // clock enable
  input  wire logic [AW-1:0] s_axi_awaddr,   // write address
  input  wire logic          s_axi_awvalid,  // write address valid
  output logic               s_axi_awready,  // write address ready
  input  wire logic [31:0]   s_axi_wdata,    // write data
  input  wire logic [3:0]    s_axi_wstrb,    // byte strobes
  input  wire logic          s_axi_wvalid,   // write data valid
  output logic               s_axi_wready,   // write data ready
  output logic [1:0]         s_axi_bresp,    // write response
  output logic               s_axi_bvalid,   // write response valid
  input  wire logic          s_axi_bready,   // write response ready
  input  wire logic [AW-1:0] s_axi_araddr,   // read address
  input  wire logic          s_axi_arvalid,  // read address valid
  output logic               s_axi_arready,  // read address ready
  output logic [31:0]        s_axi_rdata,    // read data
  output logic [1:0]         s_axi_rresp,    // read response
  output logic               s_axi_rvalid,   // read data valid
  input  wire logic          s_axi_rready,   // read data ready
  output logic               wr_en,          // register write pulse
  output logic [AW-1:0]      wr_addr,        // register write address
  output logic [31:0]        wr_data,        // register write data
  output logic [3:0]         wr_strb,        // register write strobes
  input  wire logic          wr_err,         // write refused
  output logic [AW-1:0]      rd_addr,        // register read address
  input  wire logic [31:0]   rd_data,        // register read data
  input  wire logic          rd_err          // read refused
);
  import sapc_pkg::*;
  logic          aw_hold_reg;
  logic          w_hold_reg;
  logic [AW-1:0] awaddr_reg;
  logic [31:0]   wdata_reg;
  logic [3:0]    wstrb_reg;
  logic          aw_have;
  logic          w_have;

  assign s_axi_awready = ce && !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign aw_have = aw_hold_reg || (s_axi_awvalid && s_axi_awready);
  assign w_have  = w_hold_reg || (s_axi_wvalid && s_axi_wready);
  assign wr_en   = ce && aw_have && w_have && !s_axi_bvalid;
  assign wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
  assign rd_addr = s_axi_araddr;

  // address and data may arrive in either order; hold whichever came first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end else if (ce) begin
      if (wr_en) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_reg <= 1'b1;
          awaddr_reg  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_reg <= 1'b1;
          wdata_reg  <= s_axi_wdata;
          wstrb_reg  <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (ce) begin
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? AXI_SLVERR : AXI_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= AXI_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_err ? AXI_SLVERR : AXI_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: design/sapc_decode.sv
`timescale 1ns/1ns
module sapc_decode (
  input  wire logic [15:0]        word,        // policy word of the slot
  input  wire logic [3:0]         slot,        // addressed slot
  input  wire sapc_pkg::sapc_cmd_t cmd,        // command kind
  input  wire logic               len32,       // 32-byte transfer, else 4
  input  wire logic               enc,         // write data arrives encrypted
  input  wire logic               mac_ok,      // input MAC checked good
  input  wire logic               for_verify,  // digest feeds a MAC verify
  input  wire logic               copy_req,    // MAC verify copies this slot
  input  wire logic               dz_locked,   // data zone locked
  input  wire logic               cz_locked,   // config zone locked
  output logic                    grant,       // access permitted
  output logic [3:0]              key_slot,    // key slot to use
  output logic                    encrypt,     // read data leave encrypted
  output logic                    mac_req,     // MAC demanded
  output logic                    limited,     // key is limited-use
  output logic                    parent_src   // derive from parent key
);
  import sapc_pkg::*;
  logic [3:0] rk;
  logic [3:0] wk;
  logic [3:0] wp;
  logic       verify;
  logic       ciph;
  logic       sec;

  assign rk     = word[RDKEY_LSB +: 4];
  assign wk     = word[WKEY_LSB +: 4];
  assign wp     = word[WPOL_LSB +: 4];
  assign verify = word[VERIFY_BIT];
  assign ciph   = word[CIPHER_BIT];
  assign sec    = word[SECRET_BIT];

  always_comb begin
    grant      = 1'b0;
    key_slot   = 4'h0;
    encrypt    = 1'b0;
    mac_req    = 1'b0;
    parent_src = 1'b0;
    limited    = word[LIMITED_BIT] && !(slot >= LIMIT_IGN_LO && slot <= LIMIT_IGN_HI);
    case (cmd)
      CMD_READ: begin
        if (cz_locked && dz_locked) begin
          if (!sec && !ciph) begin
            grant = 1'b1;
          end else if (sec && ciph && len32) begin
            grant    = 1'b1;
            encrypt  = 1'b1;
            key_slot = rk;
          end
        end
      end
      CMD_WRITE: begin
        if (cz_locked) begin
          if (!dz_locked) begin
            grant = 1'b1;
          end else if (wp[2]) begin
            mac_req  = 1'b1;
            key_slot = wk;
            grant    = enc && mac_ok && len32;
          end else if (wp[3:1] == 3'h0) begin
            grant = len32 || !sec;
          end
        end
      end
      CMD_DERIVE: begin
        if (wp[1]) begin
          parent_src = wp[0];
          key_slot   = wp[0] ? wk : slot;
          mac_req    = wp[3];
          grant      = (!wp[3] || mac_ok) && !verify;
        end
      end
      CMD_MAC_VERIFY: begin
        key_slot = slot;
        grant    = !copy_req || rk == 4'h0;
      end
      CMD_DIGEST: begin
        key_slot = slot;
        grant    = !verify || for_verify;
      end
      default: begin
        key_slot = slot;
        grant    = !verify;
      end
    endcase
    if (!grant) begin
      key_slot   = 4'h0;
      encrypt    = 1'b0;
      mac_req    = 1'b0;
      parent_src = 1'b0;
    end
  end
endmodule

// File: test/sapc_host_model.sv
`timescale 1ns/1ns
module sapc_host_model (
  input  wire logic      aclk,           // clock
  input  wire logic      req_ready,      // request taken
  output logic           req_valid,      // access request
  output sapc_pkg::sapc_cmd_t req_cmd,   // command kind
  output logic [3:0]     req_slot,       // target slot
  output logic           req_len32,      // 32-byte transfer
  output logic           req_encrypted,  // data encrypted
  output logic           req_mac_ok,     // input MAC good
  output logic           req_for_verify, // digest feeds verify
  output logic           req_copy        // verify copy
);
  import sapc_pkg::*;
  logic taken;
  initial begin
    req_valid = 1'b0;
    req_cmd = CMD_READ;
    req_slot = 4'h0;
    {req_len32, req_encrypted, req_mac_ok, req_for_verify, req_copy} = 5'h00;
  end
  always @(posedge aclk) taken <= req_valid & req_ready;
  // request held until seen taken; released qualifiers are inverted, not kept
  task automatic issue(input sapc_cmd_t c, input logic [3:0] s, input logic [4:0] q);
    int n;
    n = 0;
    @(posedge aclk);
    #1;
    req_valid <= 1'b1;
    req_cmd <= c;
    req_slot <= s;
    {req_len32, req_encrypted, req_mac_ok, req_for_verify, req_copy} <= q;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (!taken && n < 50);
    req_valid <= 1'b0;
    {req_len32, req_encrypted, req_mac_ok, req_for_verify, req_copy} <= ~q;
  endtask
endmodule

// File: test/sapc_checker_tb.sv
`timescale 1ns/1ns
module sapc_checker_tb;
  import sapc_pkg::*;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, req_valid, req_ready;
  logic        req_len32, req_encrypted, req_mac_ok, req_for_verify, req_copy, rsp_valid, rsp_grant;
  logic        rsp_error, rsp_encrypt, rsp_mac_req, rsp_limited, rsp_parent_src;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb, req_slot, rsp_key_slot;
  logic [1:0]  s_axi_bresp, s_axi_rresp, br_q, rr_q;
  logic [4:0]  hs;
  sapc_cmd_t   req_cmd;
  int          err_total = 0;
  int          check_count = 0;
  int          cyc = 0;
  localparam logic [10:0] GR = 11'h600, RF = 11'h500, ALL = 11'h7FF, TOP = 11'h700;
  logic [19:0] pol [8] = '{20'h10000, 20'h20080, 20'h300C5, 20'h46780, 20'h5B980, 20'h60090, 20'h70020, 20'h90020};
  wire  [10:0] rv = {rsp_valid, rsp_grant, rsp_error, rsp_encrypt, rsp_key_slot, rsp_mac_req, rsp_limited,
                     rsp_parent_src};
  sapc_checker dut_u (.*);
  sapc_host_model host_u (.*);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // handshakes and answers as seen at the edge itself
  always @(posedge aclk) begin
    hs <= {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid & s_axi_bready,
           s_axi_arvalid & s_axi_arready, s_axi_rvalid & s_axi_rready};
    {br_q, rr_q, rd_q} <= {s_axi_bresp, s_axi_rresp, s_axi_rdata};
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      final_report;
    end
  end
  task automatic final_report;
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    #1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      #1;
      if (hs[4]) s_axi_awvalid <= 1'b0;
      if (hs[3]) s_axi_wvalid <= 1'b0;
      n++;
    end while (!hs[2] && n < 50);
    s_axi_bready <= 1'b0;
    chk("bdone", {31'h0, hs[2]}, 32'h1);
    chk("bresp", {30'h0, br_q}, {30'h0, e});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    #1;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      #1;
      if (hs[1]) s_axi_arvalid <= 1'b0;
      n++;
    end while (!hs[0] && n < 50);
    s_axi_rready <= 1'b0;
    chk("rdone", {31'h0, hs[0]}, 32'h1);
    chk("rresp", {30'h0, rr_q}, {30'h0, e});
    if (e == AXI_OKAY) chk("rdata", rd_q, d);
  endtask
  task automatic rq(input sapc_cmd_t c, input logic [3:0] s, input logic [4:0] q, input logic [10:0] e, m);
    host_u.issue(c, s, q);
    chk("rsp", 32'(rv & m), 32'(e & m));
  endtask
  initial begin
    {ce, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h40;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'h3;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    rd(LOCK_OFFS, 32'h0000_5555, AXI_OKAY);
    rd(12'h070, 32'h0, AXI_SLVERR);
    rq(CMD_READ, 4'h1, 5'h10, RF, ALL);
    foreach (pol[i]) wr(POLICY_BASE + WORD_STRIDE * pol[i][19:16], {16'h0, pol[i][15:0]}, AXI_OKAY);
    rd(POLICY_BASE + 12'h00C, 32'h0000_00C5, AXI_OKAY);
    wr(LOCK_OFFS, 32'h0000_0055, AXI_OKAY);
    rd(LOCK_OFFS, 32'h0000_0055, AXI_OKAY);
    wr(POLICY_BASE, 32'h0000_0001, AXI_SLVERR);
    rq(CMD_READ, 4'h1, 5'h10, RF, ALL);
    rq(CMD_WRITE, 4'h2, 5'h00, GR, TOP);
    wr(LOCK_OFFS, 32'h0, AXI_OKAY);
    rd(LOCK_OFFS, 32'h0, AXI_OKAY);
    rq(CMD_READ, 4'h1, 5'h00, GR, ALL);
    rq(CMD_READ, 4'h1, 5'h10, GR, ALL);
    rq(CMD_READ, 4'h2, 5'h10, RF, ALL);
    rq(CMD_READ, 4'h3, 5'h10, 11'h6A8, ALL);
    rq(CMD_READ, 4'h3, 5'h00, RF, ALL);
    rq(CMD_WRITE, 4'h2, 5'h00, RF, ALL);
    rq(CMD_WRITE, 4'h1, 5'h00, GR, ALL);
    rq(CMD_WRITE, 4'h4, 5'h1C, 11'h63C, ALL);
    rq(CMD_WRITE, 4'h4, 5'h10, RF, ALL);
    rq(CMD_WRITE, 4'h5, 5'h1C, RF, ALL);
    rq(CMD_DERIVE, 4'h4, 5'h10, 11'h620, ALL);
    rq(CMD_DERIVE, 4'h5, 5'h10, RF, ALL);
    rq(CMD_DERIVE, 4'h5, 5'h14, 11'h64D, ALL);
    rq(CMD_DERIVE, 4'h1, 5'h14, RF, ALL);
    rq(CMD_CRYPTO, 4'h6, 5'h10, RF, TOP);
    rq(CMD_MAC_VERIFY, 4'h6, 5'h01, GR, TOP);
    rq(CMD_DIGEST, 4'h6, 5'h02, GR, TOP);
    rq(CMD_MAC_VERIFY, 4'h3, 5'h01, RF, TOP);
    rq(CMD_READ, 4'h7, 5'h10, 11'h602, ALL);
    rq(CMD_READ, 4'h9, 5'h10, GR, ALL);
    ce <= 1'b0;
    @(posedge aclk);
    #1;
    chk("arready", {31'h0, s_axi_arready}, 32'h0);
    ce <= 1'b1;
    rd(STATUS_OFFS, 32'h000B_0001, AXI_OKAY);
    wr(STATUS_OFFS, 32'h0, AXI_SLVERR);
    final_report;
  end
endmodule
